// ==== rtl/smcg_pkg.sv ====
// Shared constants and types for the sleep mode clock gating controller.
package smcg_pkg;

  // ****************************************************************
  // Mode selection codes
  // ****************************************************************
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADCNR = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_RSVD4 = 3'h4;
  localparam logic [2:0] MODE_RSVD5 = 3'h5;
  localparam logic [2:0] MODE_STBY = 3'h6;
  localparam logic [2:0] MODE_XSTBY = 3'h7;

  // ****************************************************************
  // Timing counts, in clock cycles
  // ****************************************************************
  localparam int STANDBY_WAKE_CYC = 6;
  localparam int HALT_EXTRA_CYC = 4;
  localparam int STARTUP_WIDTH = 16;
  localparam logic [STARTUP_WIDTH-1:0] CNT_ONE = 16'h0001;
  localparam logic [STARTUP_WIDTH-1:0] CNT_ZERO = 16'h0000;
  localparam logic [STARTUP_WIDTH-1:0] CNT_STBY = 16'h0006;
  localparam logic [STARTUP_WIDTH-1:0] CNT_HALT = 16'h0004;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [7:0] PIN_RESET = 8'hff;

  // ****************************************************************
  // Controller states, one-hot
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_SLEEP = 4'h2,
    ST_START = 4'h4,
    ST_HALT = 4'h8
  } smcg_state_type;

  // Clock domain and oscillator enables.
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic mainOsc;
    logic timerOsc;
  } smcg_clk_type;

  localparam smcg_clk_type CLK_ALL_ON = 7'h7f;

  // Wake request sources coming from same-clock logic.
  typedef struct packed {
    logic extReset;
    logic wdtReset;
    logic bodReset;
    logic twiMatch;
    logic timer0Irq;
    logic spmReady;
    logic adcDone;
    logic anyIrq;
    logic [3:0] lowerIrq;
  } smcg_wake_type;

endpackage

// ==== rtl/smcg_sleep_ctrl.sv ====
// Sleep mode controller: clock gating, wake-up sequencing, power switches.
`timescale 1ns/100ps

module smcg_sleep_ctrl #(
  parameter int CW = smcg_pkg::STARTUP_WIDTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic sleepExec,
  input wire logic sleepEnableBit,
  input wire logic [2:0] sleepModeSelect,
  input wire logic extCrystalOption,
  input wire logic timer0AsyncSelect,
  input wire logic timer0OvfIrq,
  input wire logic timer0CmpIrq,
  input wire logic timer0OvfEnable,
  input wire logic timer0CmpEnable,
  input wire logic globalIrqEnable,
  input wire logic timer0Written,
  input wire smcg_pkg::smcg_wake_type wakeIn,
  input wire logic [7:0] extIrqPin,
  input wire logic [3:0] upperLevelEnable,
  input wire logic [3:0] lowerIrqEnable,
  input wire logic [CW-1:0] startupCycles,
  input wire logic adcEnable,
  input wire logic adcUsesRef,
  input wire logic adcConvStarted,
  input wire logic compEnable,
  input wire logic compUsesRef,
  input wire logic brownoutEnableFuse,
  input wire logic wdtEnable,
  input wire logic debugEnableFuse,
  input wire logic testPortEnableFuse,
  input wire logic interfaceDisableBit,
  input wire logic tapShifting,
  input wire logic tdoData,
  output smcg_pkg::smcg_clk_type clkEn_q,
  output logic sleeping_q,
  output logic adcAutoStart_q,
  output logic adcExtended_q,
  output logic compAutoOff_q,
  output logic vrefEnable_q,
  output logic bodActive_q,
  output logic wdtRun_q,
  output logic digInputEnable_q,
  output logic wakeInputEnable_q,
  output logic jtagEnable_q,
  output logic tdoOut_q,
  output logic tdoOe_q,
  output logic irqResume_q,
  output logic resetWake_q,
  output logic timer0Undefined_q
);
  import smcg_pkg::*;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Clock enables while asleep in a given mode.
  function automatic smcg_clk_type clkFor(input logic [2:0] m,
                                          input logic as0,
                                          input logic dbg);
    smcg_clk_type c;
    c = '0;
    case (m)
      MODE_IDLE:
      begin
        c.io = 1'b1;
        c.adc = 1'b1;
        c.asy = 1'b1;
        c.mainOsc = 1'b1;
        c.timerOsc = as0;
      end
      MODE_ADCNR:
      begin
        c.adc = 1'b1;
        c.asy = 1'b1;
        c.mainOsc = 1'b1;
        c.timerOsc = as0;
      end
      MODE_PDOWN: c.mainOsc = dbg;
      MODE_PSAVE:
      begin
        c.asy = as0;
        c.timerOsc = as0;
        c.mainOsc = dbg;
      end
      MODE_STBY: c.mainOsc = 1'b1;
      MODE_XSTBY:
      begin
        c.asy = as0;
        c.timerOsc = as0;
        c.mainOsc = 1'b1;
      end
      default: c = CLK_ALL_ON;
    endcase
    return c;
  endfunction

  // True for modes that stop everything but asynchronous logic.
  function automatic logic isDeep(input logic [2:0] m);
    return (m != MODE_IDLE) && (m != MODE_ADCNR);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  smcg_state_type state_q, state_d;
  logic [2:0] mode_q, mode_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic rstWake_q, rstWake_d;
  logic [7:0] pinMeta_q, pinSync_q;
  logic adcEnPrev_q;

  // ****************************************************************
  // Decoding
  // ****************************************************************

  // Standby modes only exist with a crystal; reserved codes do nothing.
  wire modeValid = (sleepModeSelect[2] == 1'b0) ||
                   (sleepModeSelect[1] && extCrystalOption);
  wire enterSleep = (state_q == ST_ACTIVE) && sleepExec &&
                    sleepEnableBit && modeValid;

  // Upper lines wake on a held low level, seen after the synchroniser.
  wire [3:0] upperLevel = ~pinSync_q[7:4] & upperLevelEnable;
  wire extWake = (|upperLevel) || (|wakeIn.lowerIrq);
  wire anyReset = wakeIn.extReset || wakeIn.wdtReset || wakeIn.bodReset;
  wire asyncTimerWake = timer0AsyncSelect && globalIrqEnable &&
                        ((timer0OvfIrq && timer0OvfEnable) ||
                         (timer0CmpIrq && timer0CmpEnable));
  wire deepMode = isDeep(mode_q);
  wire saveMode = (mode_q == MODE_PSAVE) || (mode_q == MODE_XSTBY);

  // Interrupt wake sources allowed by the mode held at entry.
  logic wakeIrq;
  always_comb
  begin
    case (mode_q)
      MODE_IDLE: wakeIrq = wakeIn.anyIrq || extWake;
      MODE_ADCNR: wakeIrq = wakeIn.adcDone || wakeIn.twiMatch ||
                            wakeIn.timer0Irq || wakeIn.spmReady ||
                            extWake;
      MODE_PDOWN, MODE_STBY: wakeIrq = wakeIn.twiMatch || extWake;
      MODE_PSAVE, MODE_XSTBY: wakeIrq = wakeIn.twiMatch || extWake ||
                                        asyncTimerWake;
      default: wakeIrq = 1'b0;
    endcase
  end

  wire wakeAny = wakeIrq || anyReset;

  // Start-up length: fuse period for oscillator-stopping modes.
  // The sleep set is held on a named net so its fields can be selected.
  wire smcg_clk_type sleepSet = clkFor(mode_q, timer0AsyncSelect,
                                       debugEnableFuse);
  wire oscStopped = !sleepSet.mainOsc;
  wire [CW-1:0] fuseLen = (startupCycles == CNT_ZERO) ? CNT_ONE :
                          startupCycles;
  wire [CW-1:0] startLen = oscStopped ? fuseLen :
                           (deepMode ? CNT_STBY : CNT_ZERO);

  // ****************************************************************
  // Sequencer
  // ****************************************************************

  // Sleep, start-up wait if any, four halted cycles unless a reset woke it, then back to running.
  always_comb
  begin
    state_d = state_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    rstWake_d = rstWake_q;
    case (state_q)
      ST_ACTIVE:
      begin
        if (enterSleep)
        begin
          state_d = ST_SLEEP;
          mode_d = sleepModeSelect;
        end
      end
      ST_SLEEP:
      begin
        if (wakeAny)
        begin
          rstWake_d = anyReset;
          if (startLen != CNT_ZERO)
          begin
            state_d = ST_START;
            cnt_d = startLen;
          end
          else if (anyReset)
            state_d = ST_ACTIVE;
          else
          begin
            state_d = ST_HALT;
            cnt_d = CNT_HALT;
          end
        end
      end
      ST_START:
      begin
        if (cnt_q == CNT_ONE)
        begin
          state_d = rstWake_q ? ST_ACTIVE : ST_HALT;
          cnt_d = CNT_HALT;
        end
        else
          cnt_d = cnt_q - CNT_ONE;
      end
      ST_HALT:
      begin
        if (cnt_q == CNT_ONE)
          state_d = ST_ACTIVE;
        else
          cnt_d = cnt_q - CNT_ONE;
      end
      default: state_d = ST_ACTIVE;
    endcase
  end

  wire toActive = (state_q != ST_ACTIVE) && (state_d == ST_ACTIVE);
  wire asleep = (state_q == ST_SLEEP) || (state_q == ST_START);

  // ****************************************************************
  // Output decoding
  // ****************************************************************

  // While restarting, the oscillator joins the sleep clock set; halt keeps cpu stopped.
  smcg_clk_type haltClk, startClk, clk_d;
  always_comb
  begin
    haltClk = CLK_ALL_ON;
    haltClk.cpu = 1'b0;
    haltClk.flash = 1'b0;
    startClk = clkFor(mode_q, timer0AsyncSelect, debugEnableFuse);
    startClk.mainOsc = 1'b1;
    case (state_q)
      ST_SLEEP: clk_d = clkFor(mode_q, timer0AsyncSelect, debugEnableFuse);
      ST_START: clk_d = startClk;
      ST_HALT: clk_d = haltClk;
      default: clk_d = CLK_ALL_ON;
    endcase
  end

  // Conversion starts by itself when idle or noise reduction is entered with the converter enabled.
  wire autoStart_d = enterSleep && adcEnable &&
                     !isDeep(sleepModeSelect);
  // A rising converter enable marks the next conversion as extended.
  wire adcRise = adcEnable && !adcEnPrev_q;
  wire extended_d = adcRise || (adcExtended_q && !adcConvStarted);
  // Comparator self-disables while asleep or restarting in a deep mode.
  wire compOff_d = asleep && deepMode;
  wire vref_d = brownoutEnableFuse || (compEnable && compUsesRef) ||
                (adcEnable && adcUsesRef);
  // Buffers go off only when both io and converter clocks stop.
  wire inBufOff = asleep && !clk_d.io && !clk_d.adc;
  wire wakeBuf_d = !inBufOff || (|upperLevelEnable) ||
                   (|lowerIrqEnable);
  wire jtag_d = testPortEnableFuse && !interfaceDisableBit;
  wire tdoOe_d = jtag_d && tapShifting;
  // Waking from power-save with a synchronous timer spoils its contents.
  wire t0Spoil = toActive && saveMode && !timer0AsyncSelect;
  wire t0Undef_d = t0Spoil || (timer0Undefined_q && !timer0Written);
  wire resume_d = (state_q == ST_HALT) && (cnt_q == CNT_ONE);

  // ****************************************************************
  // Registers
  // ****************************************************************

  // External pin levels pass two flops before the wake logic sees them.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pinMeta_q <= PIN_RESET;
      pinSync_q <= PIN_RESET;
    end
    else if (ce)
    begin
      pinMeta_q <= extIrqPin;
      pinSync_q <= pinMeta_q;
    end
  end

  // Sequencer state.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= ST_ACTIVE;
      mode_q <= MODE_RESET;
      cnt_q <= CNT_ZERO;
      rstWake_q <= 1'b0;
      adcEnPrev_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      rstWake_q <= rstWake_d;
      adcEnPrev_q <= adcEnable;
    end
  end

  // Registered outputs; watchdog and detector follow their enables.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      clkEn_q <= CLK_ALL_ON;
      sleeping_q <= 1'b0;
      adcAutoStart_q <= 1'b0;
      adcExtended_q <= 1'b0;
      compAutoOff_q <= 1'b0;
      vrefEnable_q <= 1'b0;
      bodActive_q <= 1'b0;
      wdtRun_q <= 1'b0;
      digInputEnable_q <= 1'b1;
      wakeInputEnable_q <= 1'b1;
      jtagEnable_q <= 1'b0;
      tdoOut_q <= 1'b0;
      tdoOe_q <= 1'b0;
      irqResume_q <= 1'b0;
      resetWake_q <= 1'b0;
      timer0Undefined_q <= 1'b0;
    end
    else if (ce)
    begin
      clkEn_q <= clk_d;
      sleeping_q <= asleep;
      adcAutoStart_q <= autoStart_d;
      adcExtended_q <= extended_d;
      compAutoOff_q <= compOff_d;
      vrefEnable_q <= vref_d;
      bodActive_q <= brownoutEnableFuse;
      wdtRun_q <= wdtEnable;
      digInputEnable_q <= !inBufOff;
      wakeInputEnable_q <= wakeBuf_d;
      jtagEnable_q <= jtag_d;
      tdoOut_q <= tdoData;
      tdoOe_q <= tdoOe_d;
      irqResume_q <= resume_d;
      resetWake_q <= toActive && rstWake_d;
      timer0Undefined_q <= t0Undef_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);

  sleep_entry_a: assert property (
    (state_q == ST_ACTIVE && sleepExec && !sleepEnableBit)
    |=> state_q == ST_ACTIVE)
    else $error("Sleep entered without sleep enable.");

  reserved_nop_a: assert property (
    (state_q == ST_ACTIVE && sleepExec &&
     (sleepModeSelect == MODE_RSVD4 || sleepModeSelect == MODE_RSVD5))
    |=> state_q == ST_ACTIVE)
    else $error("Reserved mode left the running state.");

  idle_clocks_a: assert property (
    (state_q == ST_SLEEP && mode_q == MODE_IDLE) ##1 state_q == ST_SLEEP
    |-> !clkEn_q.cpu && !clkEn_q.flash && clkEn_q.io && clkEn_q.adc)
    else $error("Idle clock set wrong.");

  adcnr_clocks_a: assert property (
    (state_q == ST_SLEEP && mode_q == MODE_ADCNR) ##1 state_q == ST_SLEEP
    |-> !clkEn_q.io && !clkEn_q.cpu && clkEn_q.adc && clkEn_q.mainOsc)
    else $error("Noise-reduction clock set wrong.");

  pdown_clocks_a: assert property (
    (state_q == ST_SLEEP && mode_q == MODE_PDOWN && !debugEnableFuse)
    ##1 state_q == ST_SLEEP |-> clkEn_q == '0)
    else $error("Power-down left a clock running.");

  auto_start_a: assert property (
    (enterSleep && adcEnable && sleepModeSelect == MODE_ADCNR)
    |=> adcAutoStart_q ##1 !adcAutoStart_q)
    else $error("No single automatic conversion start.");

  halt_four_a: assert property (
    (state_q != ST_HALT ##1 state_q == ST_HALT)
    |-> state_q == ST_HALT [*4] ##1 (state_q == ST_ACTIVE && irqResume_q))
    else $error("Halt after wake not four cycles.");

  standby_six_a: assert property (
    (state_q == ST_SLEEP && mode_q[2] && wakeIrq && !anyReset)
    |=> state_q == ST_START [*6] ##1 state_q == ST_HALT)
    else $error("Standby wake not six cycles.");

  tdo_drive_a: assert property (
    tdoOe_q |-> $past(tapShifting) && $past(testPortEnableFuse) &&
                !$past(interfaceDisableBit))
    else $error("Data out driven while not shifting.");

endmodule // smcg_sleep_ctrl

// ==== bench/smcg_wake_model.sv ====
// Wake-source model: raises wake requests and external line levels.
`timescale 1ns/100ps

module smcg_wake_model #(
  parameter int HOLD = 4
) (
  input wire logic clk,
  input wire logic go,
  input wire smcg_pkg::smcg_wake_type src,
  input wire logic [3:0] upperLow,
  output smcg_pkg::smcg_wake_type wakeOut,
  output logic [7:0] pinOut
);
  import smcg_pkg::*;

  // ****************************************************************
  // Request holding
  // ****************************************************************
  int holdCnt = 0;
  smcg_wake_type srcHeld = '0;
  logic [3:0] lowHeld = 4'h0;

  // A request is latched on go and held for HOLD cycles.
  always @(posedge clk)
  begin
    if (go)
    begin
      holdCnt <= HOLD;
      srcHeld <= src;
      lowHeld <= upperLow;
    end
    else if (holdCnt > 0)
      holdCnt <= holdCnt - 1;
  end

  // The level is held long enough for the synchroniser to see it.
  assign wakeOut = (holdCnt > 0) ? srcHeld : '0;
  // Released pins go to their pull-up level, so idle lines read high.
  assign pinOut = {~((holdCnt > 0) ? lowHeld : 4'h0), 4'hf};
endmodule // smcg_wake_model

// ==== bench/testbench.sv ====
// Self-checking testbench for the sleep mode controller.
`timescale 1ns/100ps

module testbench;
  import smcg_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk = 1'b0, srst = 1'b1, sleepExec = 1'b0, sleepEnableBit = 1'b1;
  logic [2:0] sleepModeSelect = 3'h0;
  logic extCrystalOption = 1'b0, timer0AsyncSelect = 1'b1;
  logic timer0OvfIrq = 1'b0, timer0OvfEnable = 1'b1, globalIrqEnable = 1'b1;
  logic timer0Written = 1'b0, adcEnable = 1'b0, adcConvStarted = 1'b0;
  logic [3:0] upperLevelEnable = 4'h0, lowerIrqEnable = 4'hf;
  logic [15:0] startupCycles = 16'h0003;
  logic compEnable = 1'b0, compUsesRef = 1'b0, brownoutEnableFuse = 1'b1;
  logic wdtEnable = 1'b1, debugEnableFuse = 1'b0, testPortEnableFuse = 1'b0;
  logic interfaceDisableBit = 1'b0, tapShifting = 1'b0;
  logic go = 1'b0;
  logic ce = 1'b1, tdoData = 1'b0;
  logic [11:0] wSrc = 12'h000;
  logic [3:0] wLow = 4'h0;
  smcg_wake_type wakeIn;
  logic [7:0] extIrqPin;
  smcg_clk_type clkEn_q;
  logic sleeping_q, adcAutoStart_q, adcExtended_q, compAutoOff_q;
  logic vrefEnable_q, bodActive_q, wdtRun_q, digInputEnable_q;
  logic wakeInputEnable_q, jtagEnable_q, tdoOut_q, tdoOe_q;
  logic irqResume_q, resetWake_q, timer0Undefined_q;
  int errors = 0;
  int comparisons = 0;

  // Clock generator, 100 ns period.
  always #50 clk = ~clk;

  // ****************************************************************
  // Instances
  // ****************************************************************
  smcg_wake_model #(.HOLD(4)) wakeModel (.clk(clk), .go(go), .src(wSrc),
    .upperLow(wLow), .wakeOut(wakeIn), .pinOut(extIrqPin));

  smcg_sleep_ctrl DUT (.clk(clk), .srst(srst), .ce(ce),
    .sleepExec(sleepExec), .sleepEnableBit(sleepEnableBit),
    .sleepModeSelect(sleepModeSelect), .extCrystalOption(extCrystalOption),
    .timer0AsyncSelect(timer0AsyncSelect), .timer0OvfIrq(timer0OvfIrq),
    .timer0CmpIrq(1'b0), .timer0OvfEnable(timer0OvfEnable),
    .timer0CmpEnable(1'b0), .globalIrqEnable(globalIrqEnable),
    .timer0Written(timer0Written), .wakeIn(wakeIn), .extIrqPin(extIrqPin),
    .upperLevelEnable(upperLevelEnable), .lowerIrqEnable(lowerIrqEnable),
    .startupCycles(startupCycles), .adcEnable(adcEnable),
    .adcUsesRef(1'b0), .adcConvStarted(adcConvStarted),
    .compEnable(compEnable), .compUsesRef(compUsesRef),
    .brownoutEnableFuse(brownoutEnableFuse), .wdtEnable(wdtEnable),
    .debugEnableFuse(debugEnableFuse),
    .testPortEnableFuse(testPortEnableFuse),
    .interfaceDisableBit(interfaceDisableBit), .tapShifting(tapShifting),
    .tdoData(tdoData), .clkEn_q(clkEn_q), .sleeping_q(sleeping_q),
    .adcAutoStart_q(adcAutoStart_q), .adcExtended_q(adcExtended_q),
    .compAutoOff_q(compAutoOff_q), .vrefEnable_q(vrefEnable_q),
    .bodActive_q(bodActive_q), .wdtRun_q(wdtRun_q),
    .digInputEnable_q(digInputEnable_q),
    .wakeInputEnable_q(wakeInputEnable_q), .jtagEnable_q(jtagEnable_q),
    .tdoOut_q(tdoOut_q), .tdoOe_q(tdoOe_q), .irqResume_q(irqResume_q),
    .resetWake_q(resetWake_q), .timer0Undefined_q(timer0Undefined_q));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Inputs change a fixed 1 ns after the edge, never on it.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Issues the sleep instruction; auto is the start pulse one edge later.
  task automatic enter(input logic [2:0] m, output logic auto);
    sleepModeSelect = m;
    sleepExec = 1'b1;
    tick();
    sleepExec = 1'b0;
    auto = adcAutoStart_q;
    tick();
    tick();
  endtask

  task automatic raise(input logic [11:0] src, input logic [3:0] low);
    wSrc = src;
    wLow = low;
    go = 1'b1;
    tick();
    go = 1'b0;
  endtask

  // Raises a source and counts cycles until the core resumes.
  task automatic cyc(input logic [11:0] src, input logic [3:0] low,
                     output int n);
    raise(src, low);
    n = 0;
    while (irqResume_q !== 1'b1 && resetWake_q !== 1'b1 && n < 200)
    begin
      tick();
      n++;
    end
    if (n >= 200)
    begin
      errors++;
      wrap_up();
    end
    tick();
    tick();
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  logic [2:0] modes [6] = '{MODE_IDLE, MODE_ADCNR, MODE_PDOWN,
                            MODE_PSAVE, MODE_STBY, MODE_XSTBY};
  logic [6:0] sets [6] = '{7'h1f, 7'h0f, 7'h00, 7'h05, 7'h02, 7'h07};
  logic [3:0] refused [4] = '{4'h0, 4'hc, 4'hd, 4'he};
  logic [11:0] nrSrc [4] = '{12'h020, 12'h040, 12'h080, 12'h100};
  logic [2:0] tapIn [4] = '{3'h5, 3'h4, 3'h7, 3'h1};
  logic [1:0] tapExp [4] = '{2'h3, 2'h2, 2'h0, 2'h0};
  int n [6];
  int nx;
  logic auto;

  // Scenario list run from time zero; every wait is bounded.
  initial
  begin
    repeat (2) tick();
    srst = 1'b0;
    check(clkEn_q, 7'h7f);
    check({digInputEnable_q, wakeInputEnable_q, sleeping_q}, 3'h6);
    // Refused entries: enable bit low, reserved codes, standby sans crystal.
    for (int i = 0; i < 4; i++)
    begin
      sleepEnableBit = refused[i][3];
      enter(refused[i][2:0], auto);
      repeat (2) tick();
      check({sleeping_q, clkEn_q}, 8'h7f);
    end
    sleepEnableBit = 1'b1;
    extCrystalOption = 1'b1;
    adcEnable = 1'b1;
    repeat (2) tick();
    check(adcExtended_q, 1'b1);
    adcConvStarted = 1'b1;
    tick();
    adcConvStarted = 1'b0;
    tick();
    check(adcExtended_q, 1'b0);
    // Each mode: clock set, power switches, then a lower-line wake.
    for (int i = 0; i < 6; i++)
    begin
      enter(modes[i], auto);
      check(clkEn_q, sets[i]);
      check({sleeping_q, auto}, {1'b1, i < 2});
      check(compAutoOff_q, i >= 2);
      check(digInputEnable_q, i < 2);
      check({bodActive_q, wdtRun_q, vrefEnable_q}, 3'h7);
      cyc(12'h001, 4'h0, n[i]);
      check({sleeping_q, clkEn_q}, 8'h7f);
    end
    check(n[1], n[0]);
    check(n[2] - n[0], 3);
    check(n[3] - n[0], 3);
    check(n[4] - n[0], 6);
    check(n[5] - n[0], 6);
    enter(MODE_PDOWN, auto);
    cyc(12'h800, 4'h0, nx);
    check(n[2] - nx, 4);
    // Sources that must not wake power-down or noise reduction, then the ones that must.
    enter(MODE_PDOWN, auto);
    raise(12'h0f0, 4'h0);
    repeat (20) tick();
    check(sleeping_q, 1'b1);
    cyc(12'h100, 4'h0, nx);
    check(sleeping_q, 1'b0);
    enter(MODE_ADCNR, auto);
    raise(12'h010, 4'h0);
    repeat (20) tick();
    check(sleeping_q, 1'b1);
    cyc(12'h001, 4'h0, nx);
    for (int i = 0; i < 4; i++)
    begin
      enter(MODE_ADCNR, auto);
      cyc(nrSrc[i], 4'h0, nx);
      check(sleeping_q, 1'b0);
    end
    upperLevelEnable = 4'h1;
    enter(MODE_PDOWN, auto);
    cyc(12'h000, 4'h1, nx);
    check(sleeping_q, 1'b0);
    // A held-low clock enable freezes the sequencer against a wake.
    enter(MODE_PDOWN, auto);
    ce = 1'b0;
    raise(12'h001, 4'h0);
    repeat (6) tick();
    check(sleeping_q, 1'b1);
    ce = 1'b1;
    cyc(12'h001, 4'h0, nx);
    check(n[2] - nx, 0);
    check(sleeping_q, 1'b0);
    // Asynchronous timer wake needs the global enable.
    globalIrqEnable = 1'b0;
    enter(MODE_PSAVE, auto);
    timer0OvfIrq = 1'b1;
    repeat (20) tick();
    check(sleeping_q, 1'b1);
    globalIrqEnable = 1'b1;
    cyc(12'h000, 4'h0, nx);
    timer0OvfIrq = 1'b0;
    check(sleeping_q, 1'b0);
    timer0AsyncSelect = 1'b0;
    enter(MODE_PSAVE, auto);
    cyc(12'h001, 4'h0, nx);
    check(timer0Undefined_q, 1'b1);
    timer0Written = 1'b1;
    tick();
    timer0Written = 1'b0;
    tick();
    check(timer0Undefined_q, 1'b0);
    debugEnableFuse = 1'b1;
    enter(MODE_PDOWN, auto);
    check(clkEn_q.mainOsc, 1'b1);
    cyc(12'h001, 4'h0, nx);
    debugEnableFuse = 1'b0;
    // Reference follows its users; the detector fuse and the comparator are exercised, the converter's use is tied low.
    brownoutEnableFuse = 1'b0;
    adcEnable = 1'b0;
    repeat (2) tick();
    check(vrefEnable_q, 1'b0);
    compEnable = 1'b1;
    compUsesRef = 1'b1;
    repeat (2) tick();
    check(vrefEnable_q, 1'b1);
    // Test port enable and data-out drive.
    for (int i = 0; i < 4; i++)
    begin
      {testPortEnableFuse, interfaceDisableBit, tapShifting} = tapIn[i];
      tdoData = tapIn[i][0];
      repeat (2) tick();
      check({jtagEnable_q, tdoOe_q}, tapExp[i]);
      check(tdoOut_q, tapIn[i][0]);
    end
    wrap_up();
  end
endmodule // testbench
